// [design/gdf_phase_ctrl.sv]
/*
  One phase of the gate-driver control logic: PWM conditioning,
  dead time, desaturation blanking, fault timers and fault outputs,
  with an APB register slave.
  Assumes all pin and comparator inputs are asynchronous to sys_clk.
*/
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module gdf_phase_ctrl import gdf_pkg::*; #(
  parameter bit ACTIVE_LOW = 1'b0,
  parameter bit PER_PHASE = 1'b0,
  parameter int unsigned FILT = FILT_CYC, // Filter width in cycles
  parameter int unsigned BLANK = BLANK_CYC, // Blanking time in cycles
  parameter int unsigned NOV = NOV_CYC, // Non-overlap time in cycles
  parameter int unsigned HOLD = HOLD_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PWM pins and mode jumper
  input wire logic lowSidePwmIn,
  input wire logic highSidePwmIn,
  input wire logic localModeIn,
  // Primary supervisors
  input wire logic vccUvLowIn,
  input wire logic vccUvHighIn,
  input wire logic primPgoodIn,
  // Secondary supervisors
  input wire gdf_sec_t hsSecIn,
  input wire gdf_sec_t lsSecIn,
  // Gate drive outputs
  output gdf_gate_t hsGate,
  output gdf_gate_t lsGate,
  // Open-drain fault pins (bottom, top)
  input wire logic [1:0] faultPinIn,
  output logic [1:0] faultOut,
  output logic [1:0] faultOe
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  if (FILT < 1 || FILT > 4095 || BLANK < 1 || BLANK > 4095 || NOV < 1 || NOV > 4095) begin : g_badCyc
    $error("Timing counts must be 1 to 4095 cycles");
  end
  if (HOLD < 1 || HOLD > 2097151) begin : g_badHold
    $error("Hold count out of range");
  end

  // Saturating 12-bit increment
  function automatic logic [11:0] satInc(input logic [11:0] v, input int unsigned lim);
    satInc = (v >= 12'(lim)) ? v : v + 12'h001;
  endfunction : satInc

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  localparam int NIN = 18;
  logic [NIN-1:0] rawIn; // Asynchronous inputs
  logic [NIN-1:0] syncA_r; // First stage
  logic [NIN-1:0] syncB_r; // Second stage, the only reader of syncA_r
  assign rawIn = {faultPinIn, hsSecIn, lsSecIn, localModeIn, vccUvLowIn, vccUvHighIn, primPgoodIn,
                  highSidePwmIn, lowSidePwmIn};

  // Two flip-flop synchroniser for every pin
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= rawIn;
      syncB_r <= syncA_r;
    end
  end

  gdf_sec_t hsSec; // Synchronised high-side supervisors
  gdf_sec_t lsSec; // Synchronised low-side supervisors
  logic [1:0] pwmPin; // {high, low} as sampled
  logic [1:0] pwmAct; // Polarity-corrected requests
  logic localMode;
  logic vccUvLow;
  logic vccUvHigh;
  logic primPgood;
  logic [1:0] faultPin;
  assign pwmPin = syncB_r[1:0];
  assign primPgood = syncB_r[2];
  assign vccUvHigh = syncB_r[3];
  assign vccUvLow = syncB_r[4];
  assign localMode = syncB_r[5];
  assign lsSec = syncB_r[10:6];
  assign hsSec = syncB_r[15:11];
  assign faultPin = syncB_r[17:16];
  assign pwmAct = ACTIVE_LOW ? ~pwmPin : pwmPin;

  // ==========================================================
  // Anti-glitch filter, one per PWM input
  // ==========================================================
  logic [1:0] pwmFilt_r; // Accepted levels, {high, low}
  logic [11:0] filtCnt_r [2]; // Stable-time counters

  // A new level is taken only after FILT stable cycles, which also delays it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pwmFilt_r <= 2'h0;
      filtCnt_r <= '{default: 12'h000};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pwmAct[i] == pwmFilt_r[i]) begin
          filtCnt_r[i] <= 12'h000; // Pulse shorter than FILT is dropped
        end else if (filtCnt_r[i] >= 12'(FILT - 1)) begin
          pwmFilt_r[i] <= pwmAct[i]; // Accept after filter time
          filtCnt_r[i] <= 12'h000;
        end else begin
          filtCnt_r[i] <= satInc(filtCnt_r[i], FILT);
        end
      end
    end
  end

  // ==========================================================
  // Mode selection and anti-overlap
  // ==========================================================
  logic cmdHs; // High-side request
  logic cmdLs; // Low-side request
  logic [1:0] cmdPrev_r; // Previous requests for edge detect
  logic [1:0] cmdRise; // Rising request edges

  // Local mode builds both from the high input; direct mode blocks overlap
  always_comb begin
    if (localMode) begin
      cmdHs = pwmFilt_r[1];
      cmdLs = ~pwmFilt_r[1];
    end else begin
      cmdHs = pwmFilt_r[1] & ~pwmFilt_r[0];
      cmdLs = pwmFilt_r[0] & ~pwmFilt_r[1];
    end
  end

  // Request edge detector
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmdPrev_r <= 2'h0;
    end else begin
      cmdPrev_r <= {cmdHs, cmdLs};
    end
  end
  assign cmdRise = {cmdHs, cmdLs} & ~cmdPrev_r;

  // ==========================================================
  // Undervoltage hysteresis
  // ==========================================================
  logic [2:0] uv_r; // {hs, ls, vcc} undervoltage flags

  // Set below the low threshold, cleared only above the high one
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      uv_r <= 3'h7;
    end else begin
      if (vccUvLow) begin
        uv_r[0] <= 1'b1;
      end else if (vccUvHigh) begin
        uv_r[0] <= 1'b0;
      end
      if (lsSec.uvLow) begin
        uv_r[1] <= 1'b1;
      end else if (lsSec.uvHigh) begin
        uv_r[1] <= 1'b0;
      end
      if (hsSec.uvLow) begin
        uv_r[2] <= 1'b1;
      end else if (hsSec.uvHigh) begin
        uv_r[2] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Gate enables, dead time and blanking
  // ==========================================================
  logic [1:0] gateOn_r; // {hs, ls} gate drive
  logic [1:0] ssd_r; // {hs, ls} soft shutdown active
  logic [11:0] offCnt_r [2]; // Cycles since each gate turned off
  logic [11:0] blankCnt_r [2]; // Cycles since each gate turned on
  logic [1:0] sideOk; // Side allowed to switch
  logic [1:0] want; // Requested gate level
  logic [1:0] desatHit; // Qualified desaturation
  logic [1:0] rawDesat;
  logic ctrlEn; // Software gate enable
  gdf_fstate_t fst_r [3]; // Fault timers {prim, hs, ls}

  assign rawDesat = {hsSec.desat, lsSec.desat};
  assign want = {cmdHs, cmdLs};

  // Gates turn on only while enabled and the phase and their own side are in FT_OK
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sideOk[i] = ctrlEn && fst_r[2] == FT_OK && fst_r[i] == FT_OK;
      desatHit[i] = gateOn_r[i] && rawDesat[i] && blankCnt_r[i] >= 12'(BLANK);
    end
  end

  // Turn-on waits for the opposite gate to be off, and in local mode NOV cycles more
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gateOn_r <= 2'h0;
      offCnt_r <= '{default: 12'h000};
      blankCnt_r <= '{default: 12'h000};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!sideOk[i] || !want[i] || desatHit[i]) begin
          gateOn_r[i] <= 1'b0; // Held on only while request stays
        end else if (!gateOn_r[1-i] && (!localMode || offCnt_r[1-i] >= 12'(NOV))) begin
          gateOn_r[i] <= 1'b1;
        end
        offCnt_r[i] <= gateOn_r[i] ? 12'h000 : satInc(offCnt_r[i], NOV);
        blankCnt_r[i] <= gateOn_r[i] ? satInc(blankCnt_r[i], BLANK) : 12'h000;
      end
    end
  end

  // Soft shutdown replaces fast turn-off when a side faults while on
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ssd_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (gateOn_r[i] && (desatHit[i] || !sideOk[i])) begin
          ssd_r[i] <= 1'b1;
        end else if (cmdRise[i] && (fst_r[i] == FT_OK || fst_r[i] == FT_ARM) &&
                     (fst_r[2] == FT_OK || fst_r[2] == FT_ARM)) begin
          // Same edge that takes the timers from armed to running
          ssd_r[i] <= 1'b0;
        end
      end
    end
  end

  // Gate outputs; clamp engaged while the gate is off and soft shutdown is not active
  always_comb begin
    hsGate.gateOn = gateOn_r[1];
    hsGate.softOff = ssd_r[1];
    hsGate.clampOn = ~gateOn_r[1] & ~ssd_r[1];
    lsGate.gateOn = gateOn_r[0];
    lsGate.softOff = ssd_r[0];
    lsGate.clampOn = ~gateOn_r[0] & ~ssd_r[0];
  end

  // ==========================================================
  // Fault timers
  // ==========================================================
  logic [2:0] faultNow; // Present fault conditions
  logic [2:0] faultEv; // New fault events
  logic [2:0] resumeEdge; // Restart edge per domain
  logic [20:0] holdCnt_r [3]; // Hold counters

  // Primary also faults when a secondary supply is missing
  assign faultNow[0] = uv_r[1] | ~lsSec.pgood;
  assign faultNow[1] = uv_r[2] | ~hsSec.pgood;
  assign faultNow[2] = uv_r[0] | ~primPgood | ~hsSec.present | ~lsSec.present;
  assign faultEv = faultNow | {1'b0, desatHit[1], desatHit[0]};
  assign resumeEdge = {|cmdRise, cmdRise[1], cmdRise[0]};

  // Latch, hold, recheck, then wait for a rising PWM edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fst_r <= '{default: FT_WAIT};
      holdCnt_r <= '{default: 21'h000000};
    end else begin
      for (int i = 0; i < 3; i++) begin
        unique case (fst_r[i])
          FT_OK: begin
            holdCnt_r[i] <= 21'h000000;
            if (faultEv[i]) begin
              fst_r[i] <= FT_HOLD;
            end
          end
          FT_HOLD: begin
            if (holdCnt_r[i] >= 21'(HOLD - 1)) begin
              fst_r[i] <= FT_WAIT;
            end else begin
              holdCnt_r[i] <= holdCnt_r[i] + 21'h000001;
            end
          end
          FT_WAIT: begin
            if (!faultNow[i]) begin
              fst_r[i] <= FT_ARM;
            end
          end
          FT_ARM: begin
            if (faultEv[i]) begin
              fst_r[i] <= FT_HOLD;
              holdCnt_r[i] <= 21'h000000;
            end else if (resumeEdge[i]) begin
              fst_r[i] <= FT_OK;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Open-drain fault outputs
  // ==========================================================
  logic [1:0] sideFault; // {top, bottom} faulted
  logic anyFault;
  logic [1:0] faultOe_r;
  assign sideFault = {fst_r[1] != FT_OK, fst_r[0] != FT_OK} | {2{fst_r[2] != FT_OK}};
  assign anyFault = |sideFault;

  // Enable pulls the pin low; released means no fault
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      faultOe_r <= 2'h3;
    end else begin
      faultOe_r <= PER_PHASE ? {2{anyFault}} : sideFault;
    end
  end
  assign faultOe = faultOe_r;
  assign faultOut = 2'h0;

  // ==========================================================
  // APB slave
  // ==========================================================
  logic ctrlEn_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic acc;
  logic hit;
  assign acc = psel & penable;
  assign hit = (paddr == CTRL_OFS) || (paddr == STAT_OFS);
  assign ctrlEn = ctrlEn_r;

  // Control register write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrlEn_r <= CTRL_RST[CTRL_EN_BIT];
    end else if (acc && pwrite && paddr == CTRL_OFS) begin
      ctrlEn_r <= pwdata[CTRL_EN_BIT];
    end
  end

  // Read data and error registered in the setup cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_r <= ~hit;
      if (!pwrite && paddr == CTRL_OFS) begin
        prdata_r <= {31'h0000_0000, ctrlEn_r};
      end else if (!pwrite && paddr == STAT_OFS) begin
        prdata_r <= {14'h0000, localMode, faultPin, faultOe_r, uv_r, ssd_r, gateOn_r,
                     6'(fst_r[2]) << 4 | 6'(fst_r[1]) << 2 | 6'(fst_r[0])};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & acc;
  assign pready = 1'b1;

endmodule : gdf_phase_ctrl

// [design/gdf_pkg.sv]
/*
  Shared constants and types for the gate-driver phase controller.
  Assumes a 100 MHz system clock and an APB master with 32-bit data.
*/
package gdf_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FILT_NS = 500;
  localparam int unsigned FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DESAT_CAP_PF = 68;
  localparam int unsigned BLANK_NS = 14 * (DESAT_CAP_PF + 7);
  localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NOV_CAP_PF = 36;
  localparam int unsigned NOV_NS = (11 * NOV_CAP_PF) / 2;
  localparam int unsigned NOV_CYC = (NOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_MS = 14;
  localparam int unsigned HOLD_CYC = HOLD_MS * 1000000 / CLK_PERIOD_NS;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // ==========================================================
  // Fault timer states
  // ==========================================================
  typedef enum logic [1:0] {
    FT_OK = 2'b00,
    FT_HOLD = 2'b01,
    FT_WAIT = 2'b10,
    FT_ARM = 2'b11
  } gdf_fstate_t;

  // One side of the gate drive
  typedef struct packed {
    logic gateOn;
    logic softOff;
    logic clampOn;
  } gdf_gate_t;

  // Raw supervisor inputs of one secondary side
  typedef struct packed {
    logic uvLow;
    logic uvHigh;
    logic pgood;
    logic present;
    logic desat;
  } gdf_sec_t;

endpackage : gdf_pkg

// [tb/gdf_phase_ctrl_props.sv]
/*
  Port checker for one gate-driver phase controller.
  Assumes bind onto gdf_phase_ctrl, active-high PWM and NOV of 3.
*/
`timescale 1ns/1ps
module gdf_phase_ctrl_props import gdf_pkg::*; #(
  parameter int unsigned FILT = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Watched inputs
  input wire logic lowSidePwmIn,
  input wire logic localModeIn,
  input wire gdf_sec_t lsSecIn,
  // Watched outputs
  input wire gdf_gate_t hsGate,
  input wire gdf_gate_t lsGate,
  input wire logic [1:0] faultOut,
  input wire logic [1:0] faultOe
);
  // ==========================================================
  // Pin run length
  // ==========================================================
  logic [7:0] runCnt_r; // Current high run
  logic [7:0] lastRun_r; // Last finished high run
  // Tracks how long the low-side pin stayed high
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      runCnt_r <= 8'h00;
      lastRun_r <= 8'h00;
    end else if (lowSidePwmIn) begin
      runCnt_r <= (runCnt_r == 8'hFF) ? runCnt_r : runCnt_r + 8'h01;
    end else if (runCnt_r != 8'h00) begin
      lastRun_r <= runCnt_r;
      runCnt_r <= 8'h00;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Properties
  // ==========================================================
  property p_noOverlap; !(hsGate.gateOn && lsGate.gateOn); endproperty
  a_noOverlap: assert property (p_noOverlap) else $error("both gates on");
  property p_clamp;
    hsGate.clampOn == (!hsGate.gateOn && !hsGate.softOff) && lsGate.clampOn == (!lsGate.gateOn && !lsGate.softOff);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp state wrong");
  property p_openDrain; faultOut == 2'b00; endproperty
  a_openDrain: assert property (p_openDrain) else $error("fault pin driven high");
  property p_softOff; $rose(hsGate.softOff) |-> !hsGate.gateOn && $past(hsGate.gateOn); endproperty
  a_softOff: assert property (p_softOff) else $error("soft off without gate drop");
  property p_desatFlag; $rose(hsGate.softOff) |=> faultOe[1]; endproperty
  a_desatFlag: assert property (p_desatFlag) else $error("top fault not raised");
  property p_glitch;
    $rose(lsGate.gateOn) && !localModeIn |-> int'(runCnt_r) >= FILT || int'(lastRun_r) >= FILT;
  endproperty
  a_glitch: assert property (p_glitch) else $error("short pulse passed");
  property p_blank; $rose(hsGate.gateOn) |=> !$rose(hsGate.softOff) [*5]; endproperty
  a_blank: assert property (p_blank) else $error("desat during blanking");
  property p_dead; $fell(hsGate.gateOn) && localModeIn |-> !lsGate.gateOn [*3]; endproperty
  a_dead: assert property (p_dead) else $error("dead time short");
  property p_noSupply;
    !lsSecIn.present [*3] |-> ##[0:4] (faultOe == 2'b11 && !hsGate.gateOn && !lsGate.gateOn);
  endproperty
  a_noSupply: assert property (p_noSupply) else $error("no fault on lost supply");
  c_soft: cover property ($rose(hsGate.softOff));
  c_local: cover property ($rose(lsGate.gateOn) && localModeIn);
  c_clear: cover property (faultOe == 2'b11 ##1 faultOe == 2'b00);
endmodule : gdf_phase_ctrl_props

bind gdf_phase_ctrl gdf_phase_ctrl_props #(.FILT(FILT)) u_props (.sys_clk(sys_clk), .reset(reset),
  .lowSidePwmIn(lowSidePwmIn), .localModeIn(localModeIn), .lsSecIn(lsSecIn), .hsGate(hsGate),
  .lsGate(lsGate), .faultOut(faultOut), .faultOe(faultOe));

// [tb/gdf_ctrl_model.sv]
/*
  Inverter controller model: drives PWM pins, reads fault pins.
  Assumes pull-ups on both fault lines.
*/
`timescale 1ns/1ps
module gdf_ctrl_model (
  // Clock and requests
  input wire logic sys_clk,
  input wire logic hsReq,
  input wire logic lsReq,
  // Fault pin drive
  input wire logic [1:0] faultOut,
  input wire logic [1:0] faultOe,
  // Pin levels
  output logic hsPin,
  output logic lsPin,
  output logic [1:0] faultPin
);
  // Registered pin drivers, as a controller timer output would be
  always_ff @(posedge sys_clk) begin
    hsPin <= hsReq;
    lsPin <= lsReq;
  end
  // Released line goes to the pull-up level
  assign faultPin[0] = faultOe[0] ? faultOut[0] : 1'b1;
  assign faultPin[1] = faultOe[1] ? faultOut[1] : 1'b1;
endmodule : gdf_ctrl_model

// [tb/test_gate_driver_pwm_fault_logic.sv]
/*
  Self-checking bench for one gate-driver phase controller.
  Assumes short timing parameters and the controller model.
*/
`timescale 1ns/1ps
module test_gate_driver_pwm_fault_logic import gdf_pkg::*;;
  localparam int unsigned FILT_T = 6;
  localparam int unsigned BLANK_T = 10;
  localparam int unsigned HOLD_T = 20;
  logic sys_clk = 1'b0, reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic hsReq = 1'b0, lsReq = 1'b0, hsPin, lsPin, localModeIn = 1'b0;
  logic vccUvLowIn = 1'b0, vccUvHighIn = 1'b1, primPgoodIn = 1'b1;
  gdf_sec_t hsSecIn = 5'h0E, lsSecIn = 5'h0E; // Supplies good, no desat
  gdf_gate_t hsGate, lsGate;
  logic [1:0] faultPin, faultOut, faultOe;
  int n_fail = 0, cmp_count = 0, i, len;
  always #5 sys_clk = ~sys_clk;
  // ==========================================================
  // Design and far side
  // ==========================================================
  gdf_phase_ctrl #(.FILT(FILT_T), .BLANK(BLANK_T), .NOV(3), .HOLD(HOLD_T)) dut (.sys_clk(sys_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lowSidePwmIn(lsPin), .highSidePwmIn(hsPin),
    .localModeIn(localModeIn), .vccUvLowIn(vccUvLowIn), .vccUvHighIn(vccUvHighIn),
    .primPgoodIn(primPgoodIn), .hsSecIn(hsSecIn), .lsSecIn(lsSecIn), .hsGate(hsGate), .lsGate(lsGate),
    .faultPinIn(faultPin), .faultOut(faultOut), .faultOe(faultOe));
  gdf_ctrl_model u_ctrl (.sys_clk(sys_clk), .hsReq(hsReq), .lsReq(lsReq), .faultOut(faultOut),
    .faultOe(faultOe), .hsPin(hsPin), .lsPin(lsPin), .faultPin(faultPin));
  // ==========================================================
  // Helpers
  // ==========================================================
  // Pin levels {top,bottom} for given fault sources, per-side option
  function automatic logic [1:0] expFault(input bit prim, input bit hs, input bit ls);
    return {!(prim || hs), !(prim || ls)};
  endfunction : expFault
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // One APB transfer, held until pready is sampled high
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Pulse of len cycles on one side; checks whether the gate followed
  task automatic pulse(input bit s, input int l, input bit e);
    int t, on;
    on = 0;
    if (s) hsReq <= 1'b1;
    else lsReq <= 1'b1;
    for (t = 0; t < l + FILT_T + 12; t++) begin
      @(posedge sys_clk);
      if (t == l - 1) {hsReq, lsReq} <= 2'b00;
      if ((s ? hsGate.gateOn : lsGate.gateOn) === 1'b1 && on == 0) on = t + 1;
    end
    chk("gate pulse", e, on != 0);
    if (e && on != 0) chk("gate delay", 1, on >= FILT_T + 3 && on <= FILT_T + 9);
  endtask : pulse
  // Fault hold, then a fresh rising edge brings the high side back
  task automatic rearm();
    cyc(HOLD_T + 30);
    hsReq <= 1'b0;
    cyc(FILT_T + 10);
    chk("gate held off", 0, hsGate.gateOn);
    hsReq <= 1'b1;
    cyc(FILT_T + 10);
    chk("gate resumed", 1, hsGate.gateOn);
    chk("soft off cleared", 0, hsGate.softOff);
    chk("fault released", expFault(0, 0, 0), faultPin);
  endtask : rearm
  // ==========================================================
  // Watchdog and main sequence
  // ==========================================================
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
  initial begin
    void'($urandom(47));
    cyc(5);
    reset <= 1'b0;
    cyc(10);
    pulse(1, FILT_T + 6, 1);
    pulse(0, FILT_T + 6, 1);
    chk("fault idle", expFault(0, 0, 0), faultPin);
    apb(0, CTRL_OFS, 0);
    chk("ctrl reset", CTRL_RST, rd);
    apb(1, CTRL_OFS, 0);
    pulse(1, FILT_T + 6, 0);
    apb(1, CTRL_OFS, CTRL_RST);
    apb(0, 8'h08, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    pulse(1, FILT_T, 1);
    pulse(0, FILT_T - 1, 0);
    for (i = 0; i < 12; i++) begin
      len = ($urandom & 1) ? $urandom_range(FILT_T - 2, 1) : $urandom_range(3 * FILT_T, FILT_T + 2);
      pulse($urandom & 1, len, len > FILT_T);
    end
    {hsReq, lsReq} <= 2'b11;
    cyc(FILT_T + 15);
    chk("both on", 0, hsGate.gateOn | lsGate.gateOn);
    lsReq <= 1'b0;
    repeat (4) begin
      cyc(50);
      chk("full duty", 1, hsGate.gateOn);
    end
    hsReq <= 1'b0;
    cyc(FILT_T - 2);
    hsReq <= 1'b1;
    cyc(FILT_T + 10);
    chk("low glitch", 1, hsGate.gateOn);
    hsReq <= 1'b0;
    cyc(FILT_T + 10);
    hsReq <= 1'b1;
    for (i = 0; i < 200 && hsGate.gateOn !== 1'b1; i++) @(posedge sys_clk);
    hsSecIn.desat <= 1'b1;
    cyc(4);
    hsSecIn.desat <= 1'b0;
    cyc(10);
    chk("blanked desat", 0, hsGate.softOff);
    hsSecIn.desat <= 1'b1;
    cyc(6);
    chk("soft off", 1, hsGate.softOff);
    chk("gate off", 0, hsGate.gateOn);
    chk("top fault", expFault(0, 1, 0), faultPin);
    hsSecIn.desat <= 1'b0;
    rearm();
    {vccUvLowIn, vccUvHighIn} <= 2'b10;
    cyc(8);
    chk("vcc fault", expFault(1, 0, 0), faultPin);
    chk("vcc gate", 0, hsGate.gateOn);
    vccUvLowIn <= 1'b0;
    cyc(HOLD_T + 30);
    chk("hysteresis", expFault(1, 0, 0), faultPin);
    vccUvHighIn <= 1'b1;
    rearm();
    lsSecIn.present <= 1'b0;
    cyc(8);
    chk("no supply", expFault(1, 0, 0), faultPin);
    lsSecIn.present <= 1'b1;
    rearm();
    localModeIn <= 1'b1;
    cyc(FILT_T + 15);
    chk("local high", 2'b10, {hsGate.gateOn, lsGate.gateOn});
    apb(0, STAT_OFS, 0);
    chk("mode status", 1, rd[17]);
    hsReq <= 1'b0;
    cyc(FILT_T + 15);
    chk("local low", 2'b01, {hsGate.gateOn, lsGate.gateOn});
    chk("clamp", 2'b10, {hsGate.clampOn, lsGate.clampOn});
    conclude();
  end
endmodule : test_gate_driver_pwm_fault_logic
